// *** core/par_pkg.sv ***
package par_pkg;

   // clock figures
   localparam int unsigned CLK_HZ      = 250_000_000;
   localparam int unsigned LF_HZ       = 32_768;
   localparam int unsigned KEEPALIVE_S = 8;
   localparam int unsigned SEQ_MS      = 10;

   localparam int DIV_W = 13;
   localparam int TMR_W = 20;
   localparam int WDT_W = 8;
   localparam int AW    = 8;

   // register byte addresses
   localparam logic [AW-1:0] A_CTRL = 8'h00;
   localparam logic [AW-1:0] A_WDT  = 8'h04;
   localparam logic [AW-1:0] A_WCLR = 8'h08;
   localparam logic [AW-1:0] A_STAT = 8'h0c;
   localparam logic [AW-1:0] A_VOLT = 8'h10;
   localparam logic [AW-1:0] A_SCR  = 8'h14;

   // device_control field positions
   localparam int C_KEEPON = 0;
   localparam int C_AUTO   = 1;
   localparam int C_SELF   = 2;
   localparam int C_OFFHW  = 3;
   localparam int C_GCOLD  = 4;
   localparam int C_NOCLK  = 5;
   localparam int CTRL_W   = 6;
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

   localparam int W_EN   = 0;
   localparam int W_MODE = 1;
   localparam int W_PER  = 8;
   localparam logic [WDT_W-1:0] WDT_PER_RST = 8'h10;

   localparam int V_NORM  = 0;
   localparam int V_FORCE = 8;
   localparam int V_WKEEP = 15;
   localparam int VS_W    = 7;
   localparam logic [VS_W-1:0] VOLTAGE_SELECT_FIELD_DEF0 = 7'h28;
   localparam logic [VS_W-1:0] VOLTAGE_SELECT_FIELD_DEF1 = 7'h32;

   localparam int S_ST   = 0;
   localparam int S_RSTO = 4;
   localparam int S_IRQ  = 5;
   localparam int S_ACK  = 6;
   localparam int S_SEL  = 8;
   localparam int S_BANK = 10;
   localparam int S_CNT  = 16;

   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   localparam logic [1:0] POR_HOLD = 2'h3;
   localparam logic [7:0] PIN_IDLE = 8'h20;

   typedef enum logic [2:0] {
      ST_OFF  = 3'h0,
      ST_UP   = 3'h1,
      ST_ACT  = 3'h2,
      ST_DOWN = 3'h3,
      ST_WARM = 3'h4
   } par_state_t;

   typedef enum logic [1:0] {
      SEQ0 = 2'h0,
      SEQ1 = 2'h1,
      SEQ2 = 2'h2
   } par_seq_t;

   typedef struct packed {
      logic hold_pin;
      logic on_req;
      logic warm_restart_n;
      logic reset_gate;
      logic boot_select_a;
      logic boot_select_b;
      logic clk_stable;
      logic int_line;
   } par_pins_t;

   typedef struct packed {
      logic            reset_out;
      logic            wdt_irq;
      logic            por_reset;
      logic            hw_reset;
      logic            swo_reset;
      logic            seq_run;
      logic            cfg_bank;
      par_seq_t        seq_sel;
      par_state_t      state;
      logic [VS_W-1:0] voltage_select_field_norm;
      logic [VS_W-1:0] voltage_select_field_force;
   } par_out_t;

   typedef struct packed {
      logic [AW-1:0] awaddr;
      logic          awvalid;
      logic [31:0]   wdata;
      logic [3:0]    wstrb;
      logic          wvalid;
      logic          bready;
      logic [AW-1:0] araddr;
      logic          arvalid;
      logic          rready;
   } par_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } par_axi_rsp_t;

   typedef struct packed {
      par_state_t         st;
      logic [TMR_W-1:0]   tmr;
      logic [DIV_W-1:0]   div;
      logic [1:0]         por_cnt;
      logic               ack_seen;
      logic               on_prev;
      logic               warm_prev;
      logic               int_prev;
      logic               restart;
      logic [CTRL_W-1:0]  ctrl;
      logic               wdt_en;
      logic               wdt_mode;
      logic [WDT_W-1:0]   wdt_per;
      logic [WDT_W-1:0]   wdt_cnt;
      logic               warm_keep;
      logic [7:0]         scratch;
      logic               aw_have;
      logic [AW-1:0]      awaddr;
      logic               w_have;
      logic [31:0]        wdata;
      logic [3:0]         wstrb;
      par_axi_rsp_t       rsp;
      par_out_t           o;
   } par_st_t;

endpackage

// *** core/par_sync.sv ***
`timescale 1ns/1ps
module par_sync #(
   parameter int           W    = 8,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // the first stage feeds only the second stage
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge ref_clk) begin
         if (!rst_n) begin
            meta_q[i] <= INIT[i];
            q[i]      <= INIT[i];
         end else begin
            meta_q[i] <= d[i];
            q[i]      <= meta_q[i];
         end
      end
   end
endmodule

// *** core/par_top.sv ***
`timescale 1ns/1ps
// Contract
// - hold mode: power up, release reset in ACTIVE
// - unacknowledged ACTIVE shuts down after eight seconds
// - hold pin falling after raise means off
// - auto mode with self-set sets keep-on bit after power-up
// - non-self-set mode watches keep-on bit like pin
// - boot pins select config bank and sequence
// - boot pins stay visible during sequence execution
// - defaults overwritable; settings writable after sequence
// - power-on reset clears every register class
// - hardware-reset off clears hardware and switch-off
// - plain off clears only switch-off registers
// - warm restart runs power-up, ends ACTIVE
// - warm restart reloads or keeps voltage per bit
// - reset gate blocks on, forces switch-off
// - periodic watchdog irq at one, bite at period while irq uncleared
// - clearing irq never restarts periodic counter
// - watchdog counter held zero while reset low
// - interrupt mode: uncleared interrupt past period bites
// - watchdog disabled out of reset
// - normal and forced voltage share one default
// - reset released after sequence and stable clock; with C_NOCLK set the code releases it without waiting for the clock
module par_top #(
   parameter int unsigned DIV_CYC   = par_pkg::CLK_HZ / par_pkg::LF_HZ,
   parameter int unsigned KA_TICKS  = par_pkg::KEEPALIVE_S * par_pkg::LF_HZ,
   parameter int unsigned SEQ_TICKS = par_pkg::SEQ_MS * par_pkg::LF_HZ / 1000
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   input  wire par_pkg::par_pins_t    pins,
   input  wire par_pkg::par_axi_req_t axi_req,
   output par_pkg::par_axi_rsp_t      axi_rsp,
   output par_pkg::par_out_t          outs
);
   localparam int DW = par_pkg::DIV_W;
   localparam int TW = par_pkg::TMR_W;
   localparam logic [DW-1:0] DIV_M1 = DW'(DIV_CYC - 1);
   localparam logic [TW-1:0] SEQ_M1 = TW'(SEQ_TICKS - 1);
   localparam logic [TW-1:0] KA_M1  = TW'(KA_TICKS - 1);
   localparam int VS_W_L = par_pkg::VS_W;

   if (DIV_CYC < 2 || DIV_CYC > 2 ** DW) begin : g_bad_div
      $error("DIV_CYC does not fit the divider");
   end
   if (KA_TICKS < 1 || KA_TICKS > 2 ** TW || SEQ_TICKS < 1 || SEQ_TICKS > 2 ** TW) begin : g_bad_t
      $error("tick counts do not fit the timer");
   end

   par_pkg::par_st_t   s_q;
   par_pkg::par_st_t   s_d;
   par_pkg::par_pins_t p;
   logic               tick;
   logic               ack;
   logic               on_edge;
   logic               warm_edge;
   logic               int_rise;
   logic               seq_done;
   logic               clk_ok;
   logic               bite;
   logic               off_req;
   logic [VS_W_L-1:0]  vdef;
   logic [32:0]        wr_old;
   logic [32:0]        rd_val;
   logic [31:0]        wmask;
   logic [31:0]        wd;

   par_sync #(
      .W    ($bits(par_pkg::par_pins_t)),
      .INIT (par_pkg::PIN_IDLE)
   ) u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .d       (pins),
      .q       (p)
   );

   // {hit, value}; unmapped addresses miss and read zero
   function automatic logic [32:0] rd_reg(input logic [par_pkg::AW-1:0] a,
                                          input par_pkg::par_st_t s);
      logic [31:0] v;
      logic        hit;
      v   = '0;
      hit = 1'b1;
      unique case (a)
         par_pkg::A_CTRL: v[par_pkg::CTRL_W-1:0] = s.ctrl;
         par_pkg::A_WDT: begin
            v[par_pkg::W_EN]                      = s.wdt_en;
            v[par_pkg::W_MODE]                    = s.wdt_mode;
            v[par_pkg::W_PER +: par_pkg::WDT_W]   = s.wdt_per;
         end
         par_pkg::A_WCLR: v = '0;
         par_pkg::A_STAT: begin
            v[par_pkg::S_ST +: 3]                 = s.st;
            v[par_pkg::S_RSTO]                    = s.o.reset_out;
            v[par_pkg::S_IRQ]                     = s.o.wdt_irq;
            v[par_pkg::S_ACK]                     = s.ack_seen;
            v[par_pkg::S_SEL +: 2]                = s.o.seq_sel;
            v[par_pkg::S_BANK]                    = s.o.cfg_bank;
            v[par_pkg::S_CNT +: par_pkg::WDT_W]   = s.wdt_cnt;
         end
         par_pkg::A_VOLT: begin
            v[par_pkg::V_NORM +: par_pkg::VS_W]   = s.o.voltage_select_field_norm;
            v[par_pkg::V_FORCE +: par_pkg::VS_W]  = s.o.voltage_select_field_force;
            v[par_pkg::V_WKEEP]                   = s.warm_keep;
         end
         par_pkg::A_SCR: v[7:0] = s.scratch;
         default: hit = 1'b0;
      endcase
      return {hit, v};
   endfunction

   for (genvar b = 0; b < 4; b++) begin : g_strb
      assign wmask[8*b +: 8] = {8{s_q.wstrb[b]}};
   end

   assign tick      = s_q.div == DIV_M1;
   assign ack       = s_q.ctrl[par_pkg::C_AUTO] ? s_q.ctrl[par_pkg::C_KEEPON]
                                                : p.hold_pin;
   assign on_edge   = p.on_req & ~s_q.on_prev & ~p.reset_gate;
   assign warm_edge = ~p.warm_restart_n & s_q.warm_prev;
   assign int_rise  = p.int_line & ~s_q.int_prev;
   assign seq_done  = tick & (s_q.tmr == SEQ_M1);
   assign clk_ok    = p.clk_stable | s_q.ctrl[par_pkg::C_NOCLK];
   assign vdef      = p.boot_select_a ? par_pkg::VOLTAGE_SELECT_FIELD_DEF1 : par_pkg::VOLTAGE_SELECT_FIELD_DEF0;
   // a bite needs the reset released, so it only fires in ACTIVE
   assign bite      = s_q.wdt_en & s_q.o.reset_out & (s_q.wdt_per != '0)
                    & (s_q.wdt_cnt == s_q.wdt_per)
                    & (s_q.wdt_mode ? p.int_line : (s_q.o.wdt_irq & tick));
   assign off_req   = p.reset_gate | bite
                    | (s_q.ack_seen & ~ack)
                    | (~s_q.ack_seen & ~ack & tick & (s_q.tmr == KA_M1));
   assign wr_old    = rd_reg(s_q.awaddr, s_q);
   assign rd_val    = rd_reg(axi_req.araddr, s_q);
   assign wd        = (wr_old[31:0] & ~wmask) | (s_q.wdata & wmask);

   always_comb begin
      s_d           = s_q;
      s_d.div       = tick ? '0 : s_q.div + 1'b1;
      s_d.on_prev   = p.on_req;
      s_d.warm_prev = p.warm_restart_n;
      s_d.int_prev  = p.int_line;
      s_d.o.hw_reset  = 1'b0;
      s_d.o.swo_reset = 1'b0;
      s_d.o.por_reset = s_q.por_cnt != par_pkg::POR_HOLD;
      if (s_q.por_cnt != par_pkg::POR_HOLD) begin
         s_d.por_cnt = s_q.por_cnt + 1'b1;
      end
      // both voltage fields load from one default once the pins settle
      if (s_q.por_cnt == par_pkg::POR_HOLD - 2'h1) begin
         s_d.o.voltage_select_field_norm  = vdef;
         s_d.o.voltage_select_field_force = vdef;
      end

      // write channel: address and data taken in either order
      if (axi_req.awvalid & s_q.rsp.awready) begin
         s_d.aw_have = 1'b1;
         s_d.awaddr  = axi_req.awaddr;
      end
      if (axi_req.wvalid & s_q.rsp.wready) begin
         s_d.w_have = 1'b1;
         s_d.wdata  = axi_req.wdata;
         s_d.wstrb  = axi_req.wstrb;
      end
      if (s_q.rsp.bvalid & axi_req.bready) begin
         s_d.rsp.bvalid = 1'b0;
      end
      if (s_q.aw_have & s_q.w_have & ~s_q.rsp.bvalid) begin
         s_d.aw_have    = 1'b0;
         s_d.w_have     = 1'b0;
         s_d.rsp.bvalid = 1'b1;
         s_d.rsp.bresp  = wr_old[32] ? par_pkg::RESP_OK : par_pkg::RESP_ERR;
         unique case (s_q.awaddr)
            par_pkg::A_CTRL: s_d.ctrl = wd[par_pkg::CTRL_W-1:0];
            par_pkg::A_WDT: begin
               s_d.wdt_en   = wd[par_pkg::W_EN];
               s_d.wdt_mode = wd[par_pkg::W_MODE];
               s_d.wdt_per  = wd[par_pkg::W_PER +: par_pkg::WDT_W];
            end
            par_pkg::A_WCLR: begin
               if (wd[0]) begin
                  s_d.o.wdt_irq = 1'b0;
               end
            end
            par_pkg::A_VOLT: begin
               // sequence-owned settings are frozen while a sequence runs
               if (!s_q.o.seq_run) begin
                  s_d.o.voltage_select_field_norm  = wd[par_pkg::V_NORM +: par_pkg::VS_W];
                  s_d.o.voltage_select_field_force = wd[par_pkg::V_FORCE +: par_pkg::VS_W];
                  s_d.warm_keep    = wd[par_pkg::V_WKEEP];
               end
            end
            par_pkg::A_SCR: s_d.scratch = wd[7:0];
            default: s_d.scratch = s_q.scratch;
         endcase
      end
      s_d.rsp.awready = ~s_d.aw_have & ~s_d.rsp.bvalid;
      s_d.rsp.wready  = ~s_d.w_have & ~s_d.rsp.bvalid;

      // read channel
      if (s_q.rsp.rvalid & axi_req.rready) begin
         s_d.rsp.rvalid = 1'b0;
      end
      if (axi_req.arvalid & s_q.rsp.arready) begin
         s_d.rsp.rvalid = 1'b1;
         s_d.rsp.rdata  = rd_val[31:0];
         s_d.rsp.rresp  = rd_val[32] ? par_pkg::RESP_OK : par_pkg::RESP_ERR;
      end
      s_d.rsp.arready = ~s_d.rsp.rvalid;

      // power state machine
      unique case (s_q.st)
         par_pkg::ST_OFF: begin
            if (s_q.por_cnt == par_pkg::POR_HOLD
                && (on_edge || (s_q.restart && !p.reset_gate))) begin
               s_d.st       = par_pkg::ST_UP;
               s_d.tmr      = '0;
               s_d.restart  = 1'b0;
               s_d.ack_seen = 1'b0;
            end
         end
         par_pkg::ST_UP, par_pkg::ST_WARM: begin
            if (tick && s_q.tmr != SEQ_M1) begin
               s_d.tmr = s_q.tmr + 1'b1;
            end
            if (seq_done && clk_ok) begin
               s_d.st          = par_pkg::ST_ACT;
               s_d.tmr         = '0;
               s_d.o.reset_out = 1'b1;
               if (s_q.st == par_pkg::ST_UP && s_q.ctrl[par_pkg::C_AUTO]
                   && s_q.ctrl[par_pkg::C_SELF]) begin
                  s_d.ctrl[par_pkg::C_KEEPON] = 1'b1;
               end
            end
         end
         par_pkg::ST_ACT: begin
            if (ack) begin
               s_d.ack_seen = 1'b1;
            end else if (!s_q.ack_seen && tick) begin
               s_d.tmr = s_q.tmr + 1'b1;
            end
            if (off_req) begin
               s_d.st          = par_pkg::ST_DOWN;
               s_d.tmr         = '0;
               s_d.o.reset_out = 1'b0;
               s_d.restart     = p.reset_gate & s_q.ctrl[par_pkg::C_GCOLD];
            end else if (warm_edge) begin
               s_d.st          = par_pkg::ST_WARM;
               s_d.tmr         = '0;
               s_d.o.reset_out = 1'b0;
               if (!s_q.warm_keep) begin
                  s_d.o.voltage_select_field_norm  = vdef;
                  s_d.o.voltage_select_field_force = vdef;
               end
            end
         end
         par_pkg::ST_DOWN: begin
            if (tick && s_q.tmr != SEQ_M1) begin
               s_d.tmr = s_q.tmr + 1'b1;
            end
            if (seq_done) begin
               s_d.st          = par_pkg::ST_OFF;
               s_d.tmr         = '0;
               s_d.o.swo_reset = 1'b1;
               s_d.ctrl[par_pkg::C_KEEPON] = 1'b0;
               s_d.wdt_en      = 1'b0;
               s_d.wdt_mode    = 1'b0;
               s_d.wdt_per     = par_pkg::WDT_PER_RST;
               s_d.o.wdt_irq   = 1'b0;
               s_d.warm_keep   = 1'b0;
               s_d.o.voltage_select_field_norm  = vdef;
               s_d.o.voltage_select_field_force = vdef;
               if (s_q.ctrl[par_pkg::C_OFFHW]) begin
                  s_d.o.hw_reset = 1'b1;
                  s_d.scratch    = '0;
               end
            end
         end
         default: begin
            s_d.st          = par_pkg::ST_OFF;
            s_d.o.reset_out = 1'b0;
         end
      endcase

      // watchdog, after any clear so that a set in the same cycle wins
      if (!s_d.o.reset_out || !s_d.wdt_en || s_d.wdt_per == '0) begin
         s_d.wdt_cnt = '0;
      end else if (!s_d.wdt_mode) begin
         if (tick) begin
            s_d.wdt_cnt = (s_q.wdt_cnt == s_d.wdt_per) ? '0 : s_q.wdt_cnt + 1'b1;
            if (s_d.wdt_cnt == par_pkg::WDT_W'(1)) begin
               s_d.o.wdt_irq = 1'b1;
            end
         end
      end else if (int_rise || !p.int_line) begin
         s_d.wdt_cnt = '0;
      end else if (tick && s_q.wdt_cnt != s_d.wdt_per) begin
         s_d.wdt_cnt = s_q.wdt_cnt + 1'b1;
      end

      // boot pins are static selectors, read live by the sequences
      s_d.o.cfg_bank = p.boot_select_a;
      s_d.o.seq_sel  = p.boot_select_a ? par_pkg::SEQ2
                     : (p.boot_select_b ? par_pkg::SEQ1 : par_pkg::SEQ0);
      s_d.o.state    = s_d.st;
      s_d.o.seq_run  = s_d.st == par_pkg::ST_UP || s_d.st == par_pkg::ST_WARM
                    || s_d.st == par_pkg::ST_DOWN;
   end

   // reset is the power-on level: every class takes its default
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_q             <= '0;
         s_q.o.por_reset <= 1'b1;
         s_q.wdt_per     <= par_pkg::WDT_PER_RST;
         s_q.warm_prev   <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign axi_rsp = s_q.rsp;
   assign outs    = s_q.o;

   chk_reset_active: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      s_q.o.reset_out |-> s_q.st == par_pkg::ST_ACT)
      else $error("reset released outside ACTIVE");

   chk_release_cond: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(s_q.o.reset_out) |-> $past(s_q.tmr) == SEQ_M1
         && ($past(p.clk_stable) || $past(s_q.ctrl[par_pkg::C_NOCLK])))
      else $error("reset released before sequence end or clock");

   chk_keepalive_end: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      s_q.st == par_pkg::ST_ACT && !s_q.ack_seen && !ack && tick && s_q.tmr == KA_M1
      |=> s_q.st == par_pkg::ST_DOWN)
      else $error("keep-alive timeout missed");

   chk_hold_drop: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      s_q.st == par_pkg::ST_ACT && s_q.ack_seen && !ack |=> s_q.st == par_pkg::ST_DOWN)
      else $error("acknowledge drop not taken as off");

   chk_selfset_bit: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      s_q.st == par_pkg::ST_UP && s_q.ctrl[par_pkg::C_AUTO] && s_q.ctrl[par_pkg::C_SELF]
      ##1 s_q.st == par_pkg::ST_ACT |-> s_q.ctrl[par_pkg::C_KEEPON])
      else $error("keep-on bit not set after power-up");

   chk_boot_decode: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      $past(rst_n) |-> s_q.o.seq_sel == ($past(p.boot_select_a) ? par_pkg::SEQ2
         : ($past(p.boot_select_b) ? par_pkg::SEQ1 : par_pkg::SEQ0))
         && s_q.o.cfg_bank == $past(p.boot_select_a))
      else $error("boot select decode wrong");

   chk_gate_block: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      s_q.st == par_pkg::ST_OFF && p.reset_gate |=> s_q.st == par_pkg::ST_OFF)
      else $error("power-up despite reset gate");

   chk_reset_levels: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      s_q.o.hw_reset |-> s_q.o.swo_reset && s_q.st == par_pkg::ST_OFF && !s_q.wdt_en)
      else $error("hardware reset without switch-off reset");

   chk_wdt_irq_one: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !s_q.wdt_mode && s_q.wdt_cnt == par_pkg::WDT_W'(1) && $changed(s_q.wdt_cnt)
      |-> s_q.o.wdt_irq)
      else $error("periodic interrupt missing at count one");

   chk_wdt_held: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !s_q.o.reset_out |-> s_q.wdt_cnt == '0)
      else $error("watchdog counts while reset low");

   chk_wdt_bite: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      bite |=> s_q.st == par_pkg::ST_DOWN && !s_q.o.reset_out)
      else $error("watchdog expiry without shutdown");

   chk_wdt_off_reset: assert property (
      @(posedge ref_clk)
      $rose(rst_n) |-> !s_q.wdt_en && s_q.wdt_cnt == '0)
      else $error("watchdog enabled out of reset");
endmodule

// *** tb/par_host.sv ***
`timescale 1ns/1ps
module par_host (
   input  wire logic ref_clk,
   input  wire logic reset_out,
   input  wire logic en,
   output logic      hold
);
   logic [2:0] dly_q;
   initial {hold, dly_q} = '0;
   // ack lands well inside the keep-alive window
   always @(posedge ref_clk) begin
      dly_q <= (en && reset_out) ? dly_q + 3'h1 : 3'h0;
      hold <= en && (hold || dly_q == 3'h4);
   end
endmodule

// *** tb/par_top_tb.sv ***
`timescale 1ns/1ps
module par_top_tb;
   logic                  ref_clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  en = 1'b0;
   logic                  hold;
   logic [6:0]            r = 7'h26; // boot_select_b strapped high; t_warm raises boot_select_a
   logic [31:0]           rd_d;
   logic [1:0]            rd_r;
   int                    fail_count = 0;
   int                    num_checks = 0;
   int                    hw_n = 0;
   par_pkg::par_axi_req_t q = '0;
   par_pkg::par_axi_rsp_t rs;
   par_pkg::par_out_t     o;
   par_pkg::par_pins_t    pins;
   assign pins = par_pkg::par_pins_t'({hold, r});
   always #2 ref_clk = ~ref_clk;
   par_top #(.DIV_CYC(4), .KA_TICKS(20), .SEQ_TICKS(3)) dut (.ref_clk(ref_clk),
      .rst_n(rst_n), .pins(pins), .axi_req(q), .axi_rsp(rs), .outs(o));
   par_host host (.ref_clk(ref_clk), .reset_out(o.reset_out), .en(en), .hold(hold));
   // reset-level pulses stand one cycle, so count them as they pass
   always @(posedge ref_clk) begin
      if (o.hw_reset === 1'b1 && o.swo_reset === 1'b1) hw_n++;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // leading edge keeps two calls from driving q in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      q <= '{awaddr:a, awvalid:1'b1, wdata:d, wstrb:4'hf, wvalid:1'b1, bready:1'b1,
             default:'0};
      do begin
         @(posedge ref_clk);
         if (rs.awready) q.awvalid <= 1'b0;
         if (rs.wready) q.wvalid <= 1'b0;
      end while (!rs.bvalid);
      q.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      q <= '{araddr:a, arvalid:1'b1, rready:1'b1, default:'0};
      do begin
         @(posedge ref_clk);
         if (rs.arready) q.arvalid <= 1'b0;
      end while (!rs.rvalid);
      rd_d = rs.rdata;
      rd_r = rs.rresp;
      q.rready <= 1'b0;
   endtask
   task automatic wst(input par_pkg::par_state_t s);
      while (o.state !== s) @(posedge ref_clk);
   endtask
   task automatic wirq;
      while (o.wdt_irq !== 1'b1) @(posedge ref_clk);
   endtask
   task automatic to_down(output int n);
      n = 0;
      while (o.state !== par_pkg::ST_DOWN) begin
         @(posedge ref_clk);
         n++;
      end
   endtask
   task automatic warm;
      r[5] <= 1'b0;
      wst(par_pkg::ST_WARM);
      r[5] <= 1'b1;
      wst(par_pkg::ST_ACT);
   endtask
   task automatic pon;
      @(posedge ref_clk);
      r[6] <= 1'b0;
      @(posedge ref_clk);
      r[6] <= 1'b1;
      wst(par_pkg::ST_ACT);
   endtask
   task automatic t_reset;
      rd(par_pkg::A_CTRL);
      chk(rd_d, 32'h0);
      rd(par_pkg::A_WDT);
      chk(rd_d, 32'h1000);
      rd(8'h18);
      chk(32'(rd_r), 32'(par_pkg::RESP_ERR));
      chk(32'({o.voltage_select_field_norm, o.voltage_select_field_force}), 32'({2{par_pkg::VOLTAGE_SELECT_FIELD_DEF0}}));
      chk(32'({o.cfg_bank, o.seq_sel}), 32'({1'b0, par_pkg::SEQ1}));
      chk(32'({o.por_reset, o.seq_run, o.wdt_irq}), 32'h0);
   endtask
   task automatic t_hold;
      en <= 1'b1;
      pon;
      chk(32'(o.reset_out), 32'h1);
      repeat (100) @(posedge ref_clk);
      chk(32'(o.state), 32'(par_pkg::ST_ACT));
      en <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk(32'({o.seq_run, o.reset_out, o.state}), 32'({2'h2, par_pkg::ST_DOWN}));
      wst(par_pkg::ST_OFF);
   endtask
   task automatic t_ka;
      pon;
      repeat (70) @(posedge ref_clk);
      chk(32'(o.reset_out), 32'h1);
      repeat (25) @(posedge ref_clk);
      chk(32'(o.reset_out), 32'h0);
      wst(par_pkg::ST_OFF);
   endtask
   task automatic t_auto;
      wr(par_pkg::A_CTRL, 32'h6);
      pon;
      rd(par_pkg::A_CTRL);
      chk(rd_d, 32'h7);
      wr(par_pkg::A_CTRL, 32'h6);
      repeat (4) @(posedge ref_clk);
      chk(32'(o.reset_out), 32'h0);
      wst(par_pkg::ST_OFF);
      wr(par_pkg::A_CTRL, 32'h2);
      pon;
      wr(par_pkg::A_CTRL, 32'h3);
      repeat (100) @(posedge ref_clk);
      chk(32'(o.state), 32'(par_pkg::ST_ACT));
      wr(par_pkg::A_CTRL, 32'h0);
      wst(par_pkg::ST_OFF);
   endtask
   task automatic t_wdt;
      int n;
      en <= 1'b1;
      pon;
      wr(par_pkg::A_WDT, 32'h401);
      wirq;
      wr(par_pkg::A_WCLR, 32'h1);
      chk(32'(o.wdt_irq), 32'h0);
      wirq;
      chk(32'(o.reset_out), 32'h1);
      to_down(n);
      // period of four ticks, four clocks each
      chk(n, 32'h10);
      wst(par_pkg::ST_OFF);
   endtask
   task automatic t_wdint;
      int n;
      pon;
      wr(par_pkg::A_WDT, 32'h403);
      r[0] <= 1'b1;
      repeat (8) @(posedge ref_clk);
      r[0] <= 1'b0;
      repeat (40) @(posedge ref_clk);
      chk(32'(o.state), 32'(par_pkg::ST_ACT));
      r[0] <= 1'b1;
      to_down(n);
      // tick phase against the rise is free: sync, four ticks, one edge
      chk(32'(n >= 18 && n <= 21), 32'h1);
      r[0] <= 1'b0;
      wst(par_pkg::ST_OFF);
   endtask
   task automatic t_gate;
      wr(par_pkg::A_CTRL, 32'h18);
      wr(par_pkg::A_SCR, 32'h5a);
      pon;
      rd(par_pkg::A_SCR);
      chk(rd_d, 32'h5a);
      r[4] <= 1'b1;
      wst(par_pkg::ST_OFF);
      repeat (20) @(posedge ref_clk);
      chk(32'(o.state), 32'(par_pkg::ST_OFF));
      chk(hw_n, 32'h1);
      rd(par_pkg::A_SCR);
      chk(rd_d, 32'h0);
      rd(par_pkg::A_CTRL);
      chk(rd_d, 32'h18);
      r[4] <= 1'b0;
      wst(par_pkg::ST_ACT);
      chk(32'(o.reset_out), 32'h1);
   endtask
   task automatic t_warm;
      wr(par_pkg::A_VOLT, 32'h1111);
      r[3] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk(32'({o.cfg_bank, o.seq_sel}), 32'({1'b1, par_pkg::SEQ2}));
      chk(32'({o.voltage_select_field_norm, o.voltage_select_field_force}), 32'({2{7'h11}}));
      warm;
      chk(32'(o.reset_out), 32'h1);
      chk(32'({o.voltage_select_field_norm, o.voltage_select_field_force}), 32'({2{par_pkg::VOLTAGE_SELECT_FIELD_DEF1}}));
      wr(par_pkg::A_VOLT, 32'h9111);
      warm;
      chk(32'({o.voltage_select_field_norm, o.voltage_select_field_force}), 32'({2{7'h11}}));
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset;
      t_hold;
      t_ka;
      t_auto;
      t_wdt;
      t_wdint;
      t_gate;
      t_warm;
      close_out;
   end
   initial begin
      #20000;
      fail_count++;
      close_out;
   end
endmodule
